// File: rtl/trigger_route_switch.sv
/*
  Trigger routing switch: routes external interrupts 20/21 and six
  comparator outputs to interrupts, STOP release, timer restart and
  forced output stop requests under the peripheral function switch.
  Assumes a 50 MHz clk, asynchronous pins and comparator outputs,
  and a timer that gives a one-cycle counter_period pulse.
*/
`timescale 1ns/10ps
module trigger_route_switch
  import trig_route_pkg::*;
(
  input  wire logic                        clk,
  input  wire logic                        rstn,
  input  wire logic [trig_route_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]                  reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [7:0]                  reg_rdata,
  input  wire logic                        ext_interrupt_20,
  input  wire logic                        ext_interrupt_21,
  input  wire logic [5:0]                  cmp_out,
  input  wire logic [5:0]                  comparator_output_invert,
  input  wire logic [5:0]                  comparator_filter_sel_hi,
  input  wire logic [5:0]                  comparator_filter_sel_lo,
  input  wire logic [1:0]                  ext_rising_edge_en,
  input  wire logic [1:0]                  ext_falling_edge_en,
  input  wire logic [5:0]                  comparator_rising_edge_en,
  input  wire logic [5:0]                  comparator_falling_edge_en,
  input  wire logic                        counter_period,
  input  wire logic                        stop2_clear_mode,
  output logic      [1:0]                  ext_irq,
  output logic      [5:0]                  cmp_irq,
  output logic                             stop_release_req,
  output logic                             timer_restart_req,
  output logic      [5:0]                  cmp_stop_req,
  output logic                             forced_stop2_active,
  output logic      [1:0]                  adc_trigger_select
);
  import trig_route_pkg::*;

  logic             rst_meta_reg;
  logic             rst_n;
  logic [7:0]       pfs_reg;
  logic [N_IN-1:0]  sync1_reg;
  logic [N_IN-1:0]  sync2_reg;
  logic [N_IN-1:0]  lvl_in;
  logic [N_IN-1:0]  flt;
  logic [N_IN-1:0]  prev_reg;
  logic [N_IN-1:0]  rise;
  logic [N_IN-1:0]  fall;
  logic [N_IN-1:0]  en_r;
  logic [N_IN-1:0]  en_f;
  logic [N_IN-1:0]  dly_reg;
  logic [N_IN-1:0]  irq_next;
  logic [N_IN-1:0]  irq_reg;
  logic [N_IN-1:0]  wake_cap;
  logic [N_IN-1:0]  wake_vec;
  logic [N_IN-1:0]  rst_cap;
  logic [3:0]       len_vec [N_IN];
  logic [7:0]       status;
  logic             restart_stage_reg;
  logic             stop2_trig;
  logic             cmp0_nf;
  logic             cmp2_nf;
  stop2_state_t     state_reg;
  stop2_state_t     state_next;

  // Comparator filter select code to noise width in clocks
  function automatic logic [3:0] cmp_len(input logic [1:0] sel);
    case (sel)
      2'b01:   cmp_len = CMP_FILT_W1;
      2'b10:   cmp_len = CMP_FILT_W2;
      2'b11:   cmp_len = CMP_FILT_W3;
      default: cmp_len = NO_FILT;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Reset release and register port
  //////////////////////////////////////////////////////////////////////

  // Release synchroniser; assertion stays asynchronous
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end
    else
    begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // Switch register write; bit 7 is fixed at zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pfs_reg <= PFS0_RESET;
    else if (reg_wr && reg_addr == PFS0_ADDR)
      pfs_reg <= reg_wdata & PFS0_MASK;
  end

  // Live state for software
  always_comb
  begin
    status               = 8'h00;
    status[ST_EXT20_BIT] = flt[IDX_EXT20];
    status[ST_EXT21_BIT] = flt[IDX_EXT21];
    status[ST_STOP2_BIT] = forced_stop2_active;
    status[ST_WAIT_BIT]  = (state_reg == S2_WAIT_REV);
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (!reg_rd)
      reg_rdata <= 8'h00;
    else if (reg_addr == PFS0_ADDR)
      reg_rdata <= pfs_reg;
    else if (reg_addr == STATUS_ADDR)
      reg_rdata <= status;
    else
      reg_rdata <= 8'h00;
  end

  assign adc_trigger_select = {pfs_reg[ADC_HI_BIT], pfs_reg[ADC_LO_BIT]};

  //////////////////////////////////////////////////////////////////////
  // Input conditioning
  //////////////////////////////////////////////////////////////////////

  // Two-stage synchroniser; stage one feeds only stage two
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {cmp_out, ext_interrupt_21, ext_interrupt_20};
      sync2_reg <= sync1_reg;
    end
  end

  // Inversion is the only way to flip a routed comparator's polarity
  assign lvl_in = sync2_reg ^ {comparator_output_invert, 2'b00};

  // Qualification length per input
  always_comb
  begin
    len_vec[IDX_EXT20] = pfs_reg[BYPASS_BIT] ? NO_FILT : EXT20_FILT_CYC;
    len_vec[IDX_EXT21] = NO_FILT;
    for (int i = 0; i < 6; i++)
      len_vec[i+2] = cmp_len({comparator_filter_sel_hi[i],
                              comparator_filter_sel_lo[i]});
  end

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_qual
      noise_qualifier u_qual
      (
        .clk  (clk),
        .rst_n(rst_n),
        .din  (lvl_in[gi]),
        .len  (len_vec[gi]),
        .dout (flt[gi])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////
  // Edge detection and routing
  //////////////////////////////////////////////////////////////////////

  // Previous level for edge detection
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prev_reg <= '0;
    else
      prev_reg <= flt;
  end

  assign rise = flt & ~prev_reg;
  assign fall = ~flt & prev_reg;
  assign en_r = {comparator_rising_edge_en, ext_rising_edge_en};
  assign en_f = {comparator_falling_edge_en, ext_falling_edge_en};

  // Digital edge detect stage adds the extra clock
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dly_reg <= '0;
    else
      dly_reg <= (rise & en_r) | (fall & en_f);
  end

  assign cmp0_nf = ({comparator_filter_sel_hi[0], comparator_filter_sel_lo[0]} == 2'b00);
  assign cmp2_nf = ({comparator_filter_sel_hi[2], comparator_filter_sel_lo[2]} == 2'b00);

  // Routed comparators bypass the edge stage and see rising edges only
  always_comb
  begin
    irq_next = dly_reg;
    if (pfs_reg[CMP0_RS_BIT])
      irq_next[IDX_CMP0] = rise[IDX_CMP0];
    if (pfs_reg[CMP2_RS_BIT])
      irq_next[IDX_CMP2] = rise[IDX_CMP2];
  end

  // Sources allowed to release STOP
  always_comb
  begin
    wake_cap            = '0;
    wake_cap[IDX_EXT20] = ~pfs_reg[EXT20_SEL_BIT];
    wake_cap[IDX_EXT21] = ~pfs_reg[EXT21_SEL_BIT];
    wake_cap[IDX_CMP0]  = pfs_reg[CMP0_RS_BIT] & cmp0_nf;
    wake_cap[IDX_CMP2]  = pfs_reg[CMP2_RS_BIT] & cmp2_nf;
  end

  assign wake_vec = irq_next & wake_cap;

  // Sources allowed to request timer restart
  always_comb
  begin
    rst_cap            = '0;
    rst_cap[IDX_EXT20] = pfs_reg[EXT20_SEL_BIT];
    rst_cap[IDX_EXT21] = pfs_reg[EXT21_SEL_BIT];
    rst_cap[IDX_CMP0]  = ~pfs_reg[CMP0_RS_BIT];
    rst_cap[IDX_CMP2]  = ~pfs_reg[CMP2_RS_BIT];
    rst_cap[IDX_CMP1]  = 1'b1;
    rst_cap[IDX_CMP3]  = 1'b1;
  end

  // Interrupt, wake and restart outputs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_reg           <= '0;
      stop_release_req  <= 1'b0;
      restart_stage_reg <= 1'b0;
      timer_restart_req <= 1'b0;
    end
    else
    begin
      irq_reg           <= irq_next;
      stop_release_req  <= |wake_vec;
      restart_stage_reg <= |(dly_reg & rst_cap);
      timer_restart_req <= restart_stage_reg;
    end
  end

  assign ext_irq = irq_reg[IDX_EXT21:IDX_EXT20];
  assign cmp_irq = irq_reg[IDX_CMP5:IDX_CMP0];

  // Comparator stop requests are levels; 0 and 2 need their route bit
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cmp_stop_req <= '0;
    else
    begin
      cmp_stop_req    <= flt[IDX_CMP5:IDX_CMP0];
      cmp_stop_req[0] <= flt[IDX_CMP0] & pfs_reg[CMP0_RS_BIT];
      cmp_stop_req[2] <= flt[IDX_CMP2] & pfs_reg[CMP2_RS_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Forced output stop 2 sequencer
  //////////////////////////////////////////////////////////////////////

  // Level-high trigger from ext 20 only; edge enables play no part
  assign stop2_trig = pfs_reg[EXT20_SEL_BIT] & flt[IDX_EXT20];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_reg <= S2_IDLE;
    else
      state_reg <= state_next;
  end

  // A held trigger re-engages right after a period release
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      S2_IDLE:
        if (stop2_trig)
          state_next = S2_ACTIVE;
      S2_ACTIVE:
        if (!stop2_clear_mode)
        begin
          if (counter_period)
            state_next = S2_IDLE;
        end
        else if (!stop2_trig)
          state_next = S2_WAIT_REV;
      S2_WAIT_REV:
        if (stop2_trig)
          state_next = S2_ACTIVE;
        else if (counter_period)
          state_next = S2_IDLE;
      default:
        state_next = S2_IDLE;
    endcase
  end

  assign forced_stop2_active = (state_reg != S2_IDLE);

  //////////////////////////////////////////////////////////////////////
  // Assertions
  //////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_restart_out;
    ##2 timer_restart_req;
  endsequence

  a_reset_switch_zero: assert property ($rose(rst_n) |-> pfs_reg == PFS0_RESET)
    else $error("switch register not zero after reset");
  a_route0_no_wake: assert property (irq_next[IDX_CMP0] && !pfs_reg[CMP0_RS_BIT]
    && !(|(wake_vec & ~(8'h01 << IDX_CMP0))) |=> !stop_release_req)
    else $error("comparator 0 on edge path released STOP");
  a_route1_wake: assert property (pfs_reg[CMP2_RS_BIT] && cmp2_nf
    && rise[IDX_CMP2] |=> stop_release_req)
    else $error("routed comparator 2 failed to release STOP");
  a_bypass_fast: assert property (pfs_reg[BYPASS_BIT] && lvl_in[IDX_EXT20]
    && !flt[IDX_EXT20] |=> flt[IDX_EXT20])
    else $error("bypassed ext 20 not passed in one clock");
  a_filter_holds: assert property (!pfs_reg[BYPASS_BIT] && $rose(lvl_in[IDX_EXT20])
    && !flt[IDX_EXT20] |=> !flt[IDX_EXT20] [*2])
    else $error("ext 20 filter passed too early");
  a_ext21_restart: assert property (dly_reg[IDX_EXT21] && pfs_reg[EXT21_SEL_BIT]
    |-> s_restart_out)
    else $error("ext 21 restart request missing");
  a_stop2_engage: assert property (stop2_trig && state_reg == S2_IDLE
    |=> forced_stop2_active)
    else $error("stop 2 did not engage on ext 20 level");
  a_stop2_source: assert property ($rose(forced_stop2_active)
    |-> $past(flt[IDX_EXT20]) && $past(pfs_reg[EXT20_SEL_BIT]))
    else $error("stop 2 engaged without ext 20 trigger");
  a_other_no_wake: assert property ((cmp_irq & 6'h3A) != 6'h00 && ext_irq == 2'b00
    && (cmp_irq & 6'h05) == 6'h00 |-> !stop_release_req)
    else $error("comparator 1/3/4/5 able to release STOP");
  a_routed_rise_only: assert property (pfs_reg[CMP0_RS_BIT] && fall[IDX_CMP0]
    |=> !cmp_irq[0])
    else $error("routed comparator 0 fired on falling edge");
  a_restart_cause: assert property (timer_restart_req
    |-> $past(|(dly_reg & rst_cap), 2))
    else $error("restart without an allowed source");
  a_stop2_release: assert property (state_reg == S2_ACTIVE && !stop2_clear_mode
    && counter_period |=> state_reg == S2_IDLE)
    else $error("stop 2 not cleared at counter period");

endmodule // trigger_route_switch

// File: common/trig_route_pkg.sv
/*
  Constants for the trigger routing switch: register map, field
  positions, reset value, input indices, filter timing and states.
  Assumes a 50 MHz system clock.
*/
package trig_route_pkg;

  // Register map, printed offsets on the plain register port
  localparam int          ADDR_W       = 20;
  localparam logic [19:0] PFS0_ADDR    = 20'hF_05C6;
  localparam logic [19:0] STATUS_ADDR  = 20'hF_05C7;
  localparam logic [7:0]  PFS0_RESET   = 8'h00;
  localparam logic [7:0]  PFS0_MASK    = 8'h7F;

  // Field positions of peripheral_function_switch_0
  localparam int EXT20_SEL_BIT = 0;
  localparam int EXT21_SEL_BIT = 1;
  localparam int ADC_LO_BIT    = 2;
  localparam int ADC_HI_BIT    = 3;
  localparam int BYPASS_BIT    = 4;
  localparam int CMP0_RS_BIT   = 5;
  localparam int CMP2_RS_BIT   = 6;

  // Field positions of the status register
  localparam int ST_EXT20_BIT  = 0;
  localparam int ST_EXT21_BIT  = 1;
  localparam int ST_STOP2_BIT  = 2;
  localparam int ST_WAIT_BIT   = 3;

  // Input vector indices
  localparam int N_IN      = 8;
  localparam int IDX_EXT20 = 0;
  localparam int IDX_EXT21 = 1;
  localparam int IDX_CMP0  = 2;
  localparam int IDX_CMP1  = 3;
  localparam int IDX_CMP2  = 4;
  localparam int IDX_CMP3  = 5;
  localparam int IDX_CMP4  = 6;
  localparam int IDX_CMP5  = 7;

  // Filter timing; the least qualification time rounds up
  localparam int CLK_PERIOD_NS = 20;
  localparam int FILT_MIN_NS   = 55;
  localparam int FILT_MAX_NS   = 215;
  localparam int FILT_CYC_I    = (FILT_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] EXT20_FILT_CYC = 4'(FILT_CYC_I);
  localparam logic [3:0] NO_FILT        = 4'h0;

  // Comparator noise elimination widths per filter select code
  localparam logic [3:0] CMP_FILT_W1 = 4'h2;
  localparam logic [3:0] CMP_FILT_W2 = 4'h4;
  localparam logic [3:0] CMP_FILT_W3 = 4'h8;

  // Forced output stop 2 sequencer
  typedef enum logic [2:0] {
    S2_IDLE     = 3'b001,
    S2_ACTIVE   = 3'b010,
    S2_WAIT_REV = 3'b100
  } stop2_state_t;

endpackage

// File: rtl/noise_qualifier.sv
/*
  Digital noise qualifier: the output follows the input only after
  the input has differed from it for len consecutive clocks.
  Assumes din is already synchronised to clk.
*/
`timescale 1ns/10ps
module noise_qualifier
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       din,
  input  wire logic [3:0] len,
  output logic            dout
);
  logic [3:0] cnt_reg;

  // Length zero passes the level with one register of delay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dout    <= 1'b0;
      cnt_reg <= 4'h0;
    end
    else if (din == dout)
      cnt_reg <= 4'h0;
    else if ((cnt_reg + 4'h1) >= len)
    begin
      dout    <= din;
      cnt_reg <= 4'h0;
    end
    else
      cnt_reg <= cnt_reg + 4'h1;
  end
endmodule // noise_qualifier

// File: tb/timer_model.sv
/*
  Behavioural timer partner: free running counter period pulses and
  a restart input. Assumes the switch's clock and active low reset.
*/
`timescale 1ns/10ps
module timer_model
#(
  parameter int PERIOD = 16
)
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic timer_restart_req,
  output logic      counter_period
);
  int   cnt;
  logic restart_pend;

  //////////////////////////////////////////////////////////////////////////////
  // Counter restart acts one clock after the request is taken
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt            <= 0;
      restart_pend   <= 1'b0;
      counter_period <= 1'b0;
    end
    else
    begin
      restart_pend   <= timer_restart_req;
      counter_period <= (cnt == PERIOD - 1);
      if (restart_pend || cnt == PERIOD - 1)
        cnt <= 0;
      else
        cnt <= cnt + 1;
    end
  end
endmodule // timer_model

// File: tb/testbench.sv
/*
  Self-checking bench for the trigger routing switch: register port,
  pin and comparator routing, stop 2 sequencing.
  Assumes the timer model supplies counter period pulses.
*/
`timescale 1ns/10ps
module testbench;
  import trig_route_pkg::*;
  logic        clk;
  logic        rstn;
  logic [19:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic [7:0]  pins;
  logic [5:0]  cmp_inv;
  logic [5:0]  filt_hi;
  logic [5:0]  filt_lo;
  logic [1:0]  ext_rise;
  logic [1:0]  ext_fall;
  logic [5:0]  cmp_rise;
  logic [5:0]  cmp_fall;
  logic        counter_period;
  logic        clear_mode;
  logic [1:0]  ext_irq;
  logic [5:0]  cmp_irq;
  logic        stop_rel;
  logic        restart;
  logic [5:0]  cmp_stop;
  logic        stop2;
  logic [1:0]  adc_sel;
  logic [11:0] seen;
  logic        prev_cp;
  int          n_irq;
  int          fail_count;
  int          checks_done;

  trigger_route_switch DUT (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_interrupt_20(pins[0]), .ext_interrupt_21(pins[1]), .cmp_out(pins[7:2]),
    .comparator_output_invert(cmp_inv), .comparator_filter_sel_hi(filt_hi),
    .comparator_filter_sel_lo(filt_lo), .ext_rising_edge_en(ext_rise),
    .ext_falling_edge_en(ext_fall), .comparator_rising_edge_en(cmp_rise),
    .comparator_falling_edge_en(cmp_fall), .counter_period(counter_period),
    .stop2_clear_mode(clear_mode), .ext_irq(ext_irq), .cmp_irq(cmp_irq),
    .stop_release_req(stop_rel), .timer_restart_req(restart), .cmp_stop_req(cmp_stop),
    .forced_stop2_active(stop2), .adc_trigger_select(adc_sel));

  timer_model #(.PERIOD(16)) partner (.clk(clk), .rstn(rstn),
    .timer_restart_req(restart), .counter_period(counter_period));

  //////////////////////////////////////////////////////////////////////////////
  // Shared tasks; everything is sampled at the edge, before updates land
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(posedge clk);
    chk({4'h0, reg_rdata}, {4'h0, exp});
  endtask

  // Collects which outputs fired and how many interrupt pulses
  task automatic watch(input int n);
    repeat (n)
    begin
      @(posedge clk);
      seen  |= {|cmp_stop, stop2, restart, stop_rel, cmp_irq, ext_irq};
      n_irq += $countones({cmp_irq, ext_irq});
    end
  endtask

  // Stop 2 must drop the cycle after a counter period, within a bound
  task automatic drain;
    int k;
    prev_cp = 1'b1;
    for (k = 0; k < 60 && stop2 === 1'b1; k++)
    begin
      prev_cp = counter_period;
      @(posedge clk);
    end
    chk({10'h0, k < 60, prev_cp}, 12'h003);
    if (k >= 60)
      conclude();
  endtask

  // One pin pulse of hold cycles under a given switch setting
  task automatic tcase(input logic [7:0] pfs, input logic flt, input int idx,
                       input int hold, input logic [11:0] exp, input int exp_irq);
    wr(PFS0_ADDR, pfs);
    filt_lo[0] <= flt;
    watch(4);
    seen  = '0;
    n_irq = 0;
    @(posedge clk);
    pins[idx] <= 1'b1;
    watch(hold);
    pins[idx] <= 1'b0;
    watch(14);
    chk(seen, exp);
    chk(12'(n_irq), 12'(exp_irq));
    drain();
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    conclude();
  end

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    rstn = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    pins = '0;
    cmp_inv = '0;
    filt_hi = '0;
    filt_lo = '0;
    ext_rise = 2'b11;
    ext_fall = 2'b00;
    cmp_rise = 6'h3F;
    cmp_fall = 6'h3F;
    clear_mode = 1'b0;
    fail_count = 0;
    checks_done = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(PFS0_ADDR, PFS0_RESET);
    rd(STATUS_ADDR, 8'h00);
    wr(PFS0_ADDR, 8'hFF);
    rd(PFS0_ADDR, 8'h7F);
    chk(12'(adc_sel), 12'h003);
    wr(20'hF_05C8, 8'hFF);
    rd(20'hF_05C8, 8'h00);
    wr(STATUS_ADDR, 8'hFF);
    rd(STATUS_ADDR, 8'h00);
    // External pins: function select, filter and stop 2 trigger
    tcase(8'h00, 1'b0, 1, 6, 12'h102, 1);
    tcase(8'h02, 1'b0, 1, 6, 12'h202, 1);
    tcase(8'h10, 1'b0, 0, 6, 12'h101, 1);
    tcase(8'h11, 1'b0, 0, 6, 12'h601, 1);
    tcase(8'h00, 1'b0, 0, 1, 12'h000, 0);
    tcase(8'h10, 1'b0, 0, 1, 12'h101, 1);
    tcase(8'h00, 1'b0, 0, 6, 12'h101, 1);
    // Both edges of ext 21 interrupt and wake when it is not a restart source
    ext_fall <= 2'b10;
    tcase(8'h00, 1'b0, 1, 6, 12'h102, 2);
    ext_fall <= 2'b00;
    ext_rise <= 2'b00;
    tcase(8'h11, 1'b0, 0, 6, 12'h400, 0);
    ext_rise <= 2'b11;
    // Comparators; route bits set or cleared as software must
    tcase(8'h00, 1'b0, 2, 6, 12'h204, 2);
    tcase(8'h20, 1'b0, 2, 6, 12'h904, 1);
    tcase(8'h20, 1'b1, 2, 6, 12'h804, 1);
    tcase(8'h20, 1'b1, 2, 1, 12'h000, 0);
    // Wider filter codes: 4 clocks pass a 6 clock pulse, 8 clocks drop it
    filt_hi[0] <= 1'b1;
    tcase(8'h20, 1'b0, 2, 6, 12'h804, 1);
    tcase(8'h20, 1'b1, 2, 6, 12'h000, 0);
    filt_hi[0] <= 1'b0;
    tcase(8'h00, 1'b0, 4, 6, 12'h210, 2);
    tcase(8'h40, 1'b0, 4, 6, 12'h910, 1);
    tcase(8'h00, 1'b0, 3, 6, 12'hA08, 2);
    tcase(8'h00, 1'b0, 5, 6, 12'hA20, 2);
    tcase(8'h00, 1'b0, 6, 6, 12'h840, 2);
    tcase(8'h00, 1'b0, 7, 6, 12'h880, 2);
    // Inverted comparator 0: idle level high, interrupt on the pin's fall
    cmp_inv <= 6'h01;
    tcase(8'h20, 1'b0, 2, 6, 12'h904, 1);
    chk(12'(cmp_stop), 12'h001);
    cmp_inv <= 6'h00;
    // Stop 2 held across periods while the trigger stays high
    @(posedge clk);
    clear_mode <= 1'b1;
    wr(PFS0_ADDR, 8'h11);
    @(posedge clk);
    pins[0] <= 1'b1;
    repeat (8) @(posedge clk);
    // Mode 1 must hold through every period while the trigger stays high
    repeat (32)
    begin
      @(posedge clk);
      chk(12'(stop2), 12'h001);
    end
    rd(STATUS_ADDR, 8'h05);
    pins[0] <= 1'b0;
    watch(6);
    drain();
    conclude();
  end
endmodule // testbench
